// ===== core/stfm_pkg.sv
// constants and types shared by both ends of the fault monitor link
package stfm_pkg;

  localparam int unsigned CLK_MHZ            = 200;
  localparam int unsigned NUM_CH             = 5;
  // deglitch times in ns, typical figures
  localparam int unsigned OTS_DGL_NS         = 5000;
  localparam int unsigned UVOV_DGL_NS        = 3500;
  localparam int unsigned CP_DGL_NS          = 4000;
  localparam int unsigned OTS_DGL_CYC        = OTS_DGL_NS * CLK_MHZ / 1000;
  localparam int unsigned UVOV_DGL_CYC       = UVOV_DGL_NS * CLK_MHZ / 1000;
  localparam int unsigned CP_DGL_CYC         = CP_DGL_NS * CLK_MHZ / 1000;
  localparam int unsigned DGL_W              = 11;
  // autorestart interval in ms
  localparam int unsigned RETRY_MS           = 64;
  localparam int unsigned RETRY_CYC          = RETRY_MS * CLK_MHZ * 1000;
  localparam int unsigned RETRY_W            = 24;

  // quick status word layout
  localparam int unsigned QS_OTS_LSB         = 0;
  localparam int unsigned QS_PUMP            = 5;
  localparam int unsigned QS_GDF             = 6;
  localparam int unsigned QS_W               = 7;
  // channel status word layout
  localparam int unsigned CS_OTS             = 0;
  localparam int unsigned CS_GDF             = 1;
  localparam int unsigned CS_W               = 2;
  // device status word layout
  localparam int unsigned DS_LOW             = 0;
  localparam int unsigned DS_HIGH            = 1;
  localparam int unsigned DS_GDF             = 2;
  localparam int unsigned DS_W               = 3;

  typedef enum logic [1:0] {
    STFM_RD_QUICK  = 2'b00,
    STFM_RD_CHAN   = 2'b01,
    STFM_RD_DEVICE = 2'b10
  } stfm_rd_type;

  typedef enum logic [1:0] {
    STFM_PWR_UP  = 2'b00,
    STFM_RUN     = 2'b01,
    STFM_HOLD    = 2'b10
  } stfm_pwr_type;

endpackage

// ===== core/stfm_if.sv
// command and status link between controller and fault monitor
interface stfm_if
  import stfm_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic resetn_i
);
  logic                  on_wr;
  logic [NUM_CH-1:0]     on_bits;
  logic                  rd_req;
  stfm_rd_type           rd_sel;
  logic [2:0]            rd_ch;
  logic                  rd_ack;
  logic [QS_W-1:0]       rd_data;
  logic                  warn_threshold_select;

  modport dev (
    input  on_wr, on_bits, rd_req, rd_sel, rd_ch, warn_threshold_select,
    output rd_ack, rd_data
  );
  modport ctl (
    output on_wr, on_bits, rd_req, rd_sel, rd_ch, warn_threshold_select,
    input  rd_ack, rd_data
  );
endinterface

// ===== core/stfm_monitor.sv
// fault supervision: deglitch, output gating, latched flags, restart
module stfm_monitor
  import stfm_pkg::*;
#(
  parameter int unsigned RETRY_CYCLES = RETRY_CYC
) (
  // clock and reset
  input  wire logic              clk_sys_i,
  input  wire logic              resetn_i,
  // controller link
  stfm_if.dev                    link,
  // analog comparator inputs, asynchronous
  input  wire logic [NUM_CH-1:0] overtemp_raw_i,
  input  wire logic              supply_low_raw_i,
  input  wire logic              supply_high_raw_i,
  input  wire logic              load_dump_raw_i,
  input  wire logic              pump_bad_raw_i,
  // mode from the mode logic
  input  wire logic              fail_mode_i,
  input  wire logic              mode_change_i,
  // outputs
  output logic      [NUM_CH-1:0] out_en_o,
  output logic      [NUM_CH-1:0] inrush_current_window_o,
  output logic                   warn_low_threshold_o
);

  localparam int unsigned NSRC = NUM_CH + 4;
  localparam int unsigned SRC_LOW  = NUM_CH;
  localparam int unsigned SRC_HIGH = NUM_CH + 1;
  localparam int unsigned SRC_LD   = NUM_CH + 2;
  localparam int unsigned SRC_CP   = NUM_CH + 3;
  // pump reads bad out of reset, so outputs wait for clean samples
  localparam logic [NSRC-1:0] SYNC_RST = NSRC'(1) << SRC_CP;
  localparam logic [DGL_W-1:0] OTS_N  = DGL_W'(OTS_DGL_CYC);
  localparam logic [DGL_W-1:0] UVOV_N = DGL_W'(UVOV_DGL_CYC);
  localparam logic [DGL_W-1:0] CP_N   = DGL_W'(CP_DGL_CYC);

  logic [NSRC-1:0] raw;
  logic [NSRC-1:0] s1_r;
  logic [NSRC-1:0] s2_r;
  logic [NSRC-1:0] s3_r;
  logic [NSRC-1:0] lvl_r;
  logic [NSRC-1:0] flt;

  assign raw = {pump_bad_raw_i, load_dump_raw_i, supply_high_raw_i,
                supply_low_raw_i, overtemp_raw_i};

  // three stage sync; a change counts once stages two and three agree
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s1_r  <= SYNC_RST;
      s2_r  <= SYNC_RST;
      s3_r  <= SYNC_RST;
      lvl_r <= SYNC_RST;
    end else begin
      s1_r <= raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      lvl_r <= (s2_r & s3_r) | (lvl_r & (s2_r | s3_r));
    end
  end

  // per source deglitch counters
  genvar g;
  generate
    for (g = 0; g < NSRC; g++) begin : g_dgl
      logic [DGL_W-1:0] cnt_r;
      logic             hit_r;
      logic [DGL_W-1:0] lim;
      assign lim = (g < NUM_CH) ? OTS_N : ((g == SRC_CP) ? CP_N : UVOV_N);
      always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
          cnt_r <= '0;
          hit_r <= 1'b0;
        end else if (!lvl_r[g]) begin
          cnt_r <= '0;
          hit_r <= 1'b0;
        end else if (cnt_r >= lim - 1'b1) begin
          hit_r <= 1'b1;
        end else begin
          cnt_r <= cnt_r + 1'b1;
        end
      end
      assign flt[g] = hit_r;
    end
  endgenerate

  // power-up: pump has not yet settled once
  stfm_pwr_type pwr_r;
  logic         pump_ok;
  assign pump_ok = !lvl_r[SRC_CP];

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pwr_r <= STFM_PWR_UP;
    end else begin
      case (pwr_r)
        STFM_PWR_UP: if (pump_ok) pwr_r <= STFM_RUN;
        STFM_RUN:    if (flt[SRC_CP]) pwr_r <= STFM_HOLD;
        STFM_HOLD:   if (pump_ok) pwr_r <= STFM_RUN;
        default:     pwr_r <= STFM_PWR_UP;
      endcase
    end
  end

  logic supply_fault;
  logic kill_all;
  assign supply_fault = flt[SRC_LOW] | flt[SRC_HIGH];
  assign kill_all = supply_fault | flt[SRC_LD] |
                    (pwr_r != STFM_RUN);

  // requested on bits, kept while outputs held off
  logic [NUM_CH-1:0] req_r;
  logic [NUM_CH-1:0] ots_lock_r;
  logic              uv_lock_r;
  logic [RETRY_W-1:0] retry_r;
  logic              retry_tick;

  assign retry_tick = (retry_r == RETRY_W'(RETRY_CYCLES - 1));

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      req_r <= '0;
    end else if (link.on_wr) begin
      req_r <= link.on_bits;
    end
  end

  // overtemp lockout per channel
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ots_lock_r <= '0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (flt[i]) begin
          ots_lock_r[i] <= 1'b1;
        end else if (fail_mode_i) begin
          if (mode_change_i && !lvl_r[i]) ots_lock_r[i] <= 1'b0;
        end else if (link.on_wr && link.on_bits[i] && !lvl_r[i]) begin
          ots_lock_r[i] <= 1'b0;
        end
      end
    end
  end

  // supply lockout and fail mode autorestart timer
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      uv_lock_r <= 1'b0;
      retry_r   <= '0;
    end else begin
      if (supply_fault) begin
        uv_lock_r <= 1'b1;
        retry_r   <= '0;
      end else if (uv_lock_r) begin
        if (fail_mode_i) begin
          retry_r <= retry_tick ? '0 : retry_r + 1'b1;
          if (retry_tick) uv_lock_r <= 1'b0;
        end else if (link.on_wr) begin
          uv_lock_r <= 1'b0;
        end
      end
    end
  end

  logic [NUM_CH-1:0] en_nxt;
  assign en_nxt = (kill_all || uv_lock_r) ? '0 :
                  (req_r & ~ots_lock_r & ~flt[NUM_CH-1:0]);

  // outputs and fresh inrush window on every off to on edge
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      out_en_o                <= '0;
      inrush_current_window_o <= '0;
      warn_low_threshold_o    <= 1'b0;
    end else begin
      out_en_o                <= en_nxt;
      inrush_current_window_o <= en_nxt & ~out_en_o;
      warn_low_threshold_o    <= link.warn_threshold_select;
    end
  end

  // latched flags: set wins over read clear
  logic [NUM_CH-1:0] ots_flag_r;
  logic              low_flag_r;
  logic              high_flag_r;
  logic              pump_flag_r;
  logic              gdf;
  logic              rd_q;
  logic              rd_c;
  logic              rd_d;
  assign rd_q = link.rd_req && link.rd_sel == STFM_RD_QUICK;
  assign rd_c = link.rd_req && link.rd_sel == STFM_RD_CHAN;
  assign rd_d = link.rd_req && link.rd_sel == STFM_RD_DEVICE;

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ots_flag_r  <= '0;
      low_flag_r  <= 1'b0;
      high_flag_r <= 1'b0;
      pump_flag_r <= 1'b0;
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (flt[i]) ots_flag_r[i] <= 1'b1;
        else if (rd_c && link.rd_ch == 3'(i) && !lvl_r[i])
          ots_flag_r[i] <= 1'b0;
      end
      if (flt[SRC_LOW]) low_flag_r <= 1'b1;
      else if (rd_d && !lvl_r[SRC_LOW]) low_flag_r <= 1'b0;
      if (flt[SRC_HIGH]) high_flag_r <= 1'b1;
      else if (rd_d && !lvl_r[SRC_HIGH]) high_flag_r <= 1'b0;
      if (flt[SRC_CP]) pump_flag_r <= 1'b1;
      else if (rd_q && !lvl_r[SRC_CP]) pump_flag_r <= 1'b0;
    end
  end

  assign gdf = low_flag_r | high_flag_r | pump_flag_r;

  // read answer one cycle after request, shows pre-clear value
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      link.rd_ack  <= 1'b0;
      link.rd_data <= '0;
    end else begin
      link.rd_ack  <= link.rd_req;
      link.rd_data <= '0;
      if (rd_q) begin
        link.rd_data[QS_OTS_LSB +: NUM_CH] <= ots_flag_r;
        link.rd_data[QS_PUMP] <= pump_flag_r;
        link.rd_data[QS_GDF]  <= gdf;
      end else if (rd_c) begin
        link.rd_data[CS_OTS] <= (link.rd_ch < 3'(NUM_CH)) ?
                                ots_flag_r[link.rd_ch] : 1'b0;
        link.rd_data[CS_GDF] <= gdf;
      end else if (rd_d) begin
        link.rd_data[DS_LOW]  <= low_flag_r;
        link.rd_data[DS_HIGH] <= high_flag_r;
        link.rd_data[DS_GDF]  <= gdf;
      end
    end
  end

endmodule

// ===== core/stfm_ctl.sv
// controller end: issues on writes and status reads over the link
module stfm_ctl
  import stfm_pkg::*;
(
  // clock and reset
  input  wire logic              clk_sys_i,
  input  wire logic              resetn_i,
  // link
  stfm_if.ctl                    link,
  // user side
  input  wire logic              on_wr_i,
  input  wire logic [NUM_CH-1:0] on_bits_i,
  input  wire logic              rd_i,
  input  wire stfm_rd_type       rd_sel_i,
  input  wire logic [2:0]        rd_ch_i,
  input  wire logic              warn_sel_i,
  output logic                   rd_valid_o,
  output logic      [QS_W-1:0]   rd_data_o
);

  // registered requests; reads clear flags
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      link.on_wr   <= 1'b0;
      link.on_bits <= '0;
      link.rd_req  <= 1'b0;
      link.rd_sel  <= STFM_RD_QUICK;
      link.rd_ch   <= '0;
      link.warn_threshold_select <= 1'b0;
    end else begin
      link.on_wr  <= on_wr_i;
      link.rd_req <= rd_i;
      if (on_wr_i) link.on_bits <= on_bits_i;
      if (rd_i) begin
        link.rd_sel <= rd_sel_i;
        link.rd_ch  <= rd_ch_i;
      end
      link.warn_threshold_select <= warn_sel_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rd_valid_o <= 1'b0;
      rd_data_o  <= '0;
    end else begin
      rd_valid_o <= link.rd_ack;
      if (link.rd_ack) rd_data_o <= link.rd_data;
    end
  end

endmodule

// ===== verification/stfm_link_properties.sv
// link checker for the fault monitor status and command interface
module stfm_link_properties
  import stfm_pkg::*;
(
  // clock and reset
  input wire logic              clk_sys_i,
  input wire logic              resetn_i,
  // link signals
  input wire logic              on_wr,
  input wire logic [NUM_CH-1:0] on_bits,
  input wire logic              rd_req,
  input wire stfm_rd_type       rd_sel,
  input wire logic [2:0]        rd_ch,
  input wire logic              rd_ack,
  input wire logic [QS_W-1:0]   rd_data,
  input wire logic              warn_threshold_select
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  property p_ack_due;
    rd_req |=> rd_ack;
  endproperty
  a_ack_due: assert property (p_ack_due)
    else $error("read not answered next cycle");
  property p_ack_cause;
    rd_ack |-> $past(rd_req);
  endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("answer without request");
  property p_pump_gdf;
    rd_ack && $past(rd_sel) == STFM_RD_QUICK && rd_data[QS_PUMP] |->
      rd_data[QS_GDF];
  endproperty
  a_pump_gdf: assert property (p_pump_gdf)
    else $error("pump flag without global flag");
  property p_low_gdf;
    rd_ack && $past(rd_sel) == STFM_RD_DEVICE && rd_data[DS_LOW] |->
      rd_data[DS_GDF];
  endproperty
  a_low_gdf: assert property (p_low_gdf)
    else $error("low flag without global flag");
  property p_high_gdf;
    rd_ack && $past(rd_sel) == STFM_RD_DEVICE && rd_data[DS_HIGH] |->
      rd_data[DS_GDF];
  endproperty
  a_high_gdf: assert property (p_high_gdf)
    else $error("high flag without global flag");
  property p_dev_gdf;
    rd_ack && $past(rd_sel) == STFM_RD_DEVICE && !rd_data[DS_GDF] |->
      rd_data[DS_W-2:0] == 2'h0;
  endproperty
  a_dev_gdf: assert property (p_dev_gdf)
    else $error("supply flag set with global clear");
  property p_chan_w;
    rd_ack && $past(rd_sel) == STFM_RD_CHAN |-> rd_data[QS_W-1:CS_W] == 0;
  endproperty
  a_chan_w: assert property (p_chan_w)
    else $error("channel word upper bits set");
  property p_dev_w;
    rd_ack && $past(rd_sel) == STFM_RD_DEVICE |-> rd_data[QS_W-1:DS_W] == 0;
  endproperty
  a_dev_w: assert property (p_dev_w)
    else $error("device word upper bits set");
endmodule

// ===== verification/supply_thermal_fault_monitor_bench.sv
// self-checking bench: controller end and monitor joined over the link
module supply_thermal_fault_monitor_bench
  import stfm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic              clk_sys_i = 1'b0;
  logic              resetn_i  = 1'b0;
  logic              on_wr_i   = 1'b0;
  logic [NUM_CH-1:0] on_bits_i = 5'h00;
  logic              rd_i      = 1'b0;
  stfm_rd_type       rd_sel_i  = STFM_RD_QUICK;
  logic [2:0]        rd_ch_i   = 3'h0;
  logic              warn_sel_i = 1'b0;
  logic [3:0]        flt       = 4'h0;
  logic [NUM_CH-1:0] ot        = 5'h00;
  logic              fail_mode_i = 1'b0;
  logic              mode_i    = 1'b0;
  logic              rd_valid_o;
  logic [QS_W-1:0]   rd_data_o;
  logic [NUM_CH-1:0] out_en_o;
  logic [NUM_CH-1:0] inrush_o;
  logic              warn_low_o;
  int                inr_count = 0;
  int                inr_base  = 0;
  int                fails = 0;
  int                check_count = 0;

  always #2.5 clk_sys_i = ~clk_sys_i;
  // counts cycles that carry any one-cycle inrush pulse
  always @(posedge clk_sys_i) if (|inrush_o) inr_count <= inr_count + 1;

  stfm_if lk (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i));
  stfm_ctl stfm_ctl_inst (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .link(lk.ctl),
    .on_wr_i(on_wr_i), .on_bits_i(on_bits_i), .rd_i(rd_i),
    .rd_sel_i(rd_sel_i), .rd_ch_i(rd_ch_i), .warn_sel_i(warn_sel_i),
    .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o));
  // short retry interval keeps the fail mode run brief
  stfm_monitor #(.RETRY_CYCLES(50)) stfm_monitor_inst (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .link(lk.dev),
    .overtemp_raw_i(ot), .supply_low_raw_i(flt[0]),
    .supply_high_raw_i(flt[1]), .load_dump_raw_i(flt[2]),
    .pump_bad_raw_i(flt[3]), .fail_mode_i(fail_mode_i),
    .mode_change_i(mode_i), .out_en_o(out_en_o),
    .inrush_current_window_o(inrush_o), .warn_low_threshold_o(warn_low_o));
  stfm_link_properties stfm_link_properties_inst (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .on_wr(lk.on_wr),
    .on_bits(lk.on_bits), .rd_req(lk.rd_req), .rd_sel(lk.rd_sel),
    .rd_ch(lk.rd_ch), .rd_ack(lk.rd_ack), .rd_data(lk.rd_data),
    .warn_threshold_select(lk.warn_threshold_select));

  task automatic results;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [QS_W-1:0] g, input logic [QS_W-1:0] e);
    check_count++;
    if (g !== e) begin
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
      fails++;
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask

  task automatic rd(input stfm_rd_type s, input logic [2:0] c,
                    input logic [QS_W-1:0] e);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    rd_i     <= 1'b1;
    rd_sel_i <= s;
    rd_ch_i  <= c;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    cyc(1);
    while (rd_valid_o !== 1'b1 && n < 20) begin
      cyc(1);
      n++;
    end
    if (n == 20) begin
      fails++;
      results();
    end else begin
      chk(rd_data_o, e);
    end
  endtask

  task automatic wr(input logic [NUM_CH-1:0] b);
    @(posedge clk_sys_i);
    on_wr_i   <= 1'b1;
    on_bits_i <= b;
    @(posedge clk_sys_i);
    on_wr_i <= 1'b0;
    cyc(8);
  endtask

  task automatic raw(input logic [3:0] f, input logic [4:0] o, input int n);
    @(posedge clk_sys_i);
    flt <= f;
    ot  <= o;
    cyc(n);
  endtask

  task automatic outs(input logic [NUM_CH-1:0] e);
    chk({2'h0, out_en_o}, {2'h0, e});
  endtask

  initial begin
    repeat (3) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    cyc(1);
    outs(5'h00);
    wr(5'h1F);
    outs(5'h1F);
    raw(4'h0, 5'h04, 500);
    raw(4'h0, 5'h00, 600);
    outs(5'h1F);
    raw(4'h0, 5'h04, 1100);
    outs(5'h1B);
    rd(STFM_RD_QUICK, 3'h2, 7'h04);
    rd(STFM_RD_CHAN, 3'h2, 7'h01);
    rd(STFM_RD_CHAN, 3'h2, 7'h01);
    raw(4'h0, 5'h00, 10);
    outs(5'h1B);
    rd(STFM_RD_CHAN, 3'h2, 7'h01);
    rd(STFM_RD_CHAN, 3'h2, 7'h00);
    wr(5'h1F);
    outs(5'h1F);
    raw(4'h1, 5'h00, 800);
    outs(5'h00);
    rd(STFM_RD_DEVICE, 3'h0, 7'h05);
    raw(4'h0, 5'h00, 10);
    outs(5'h00);
    rd(STFM_RD_DEVICE, 3'h0, 7'h05);
    rd(STFM_RD_DEVICE, 3'h0, 7'h00);
    wr(5'h1F);
    outs(5'h1F);
    raw(4'h2, 5'h00, 800);
    rd(STFM_RD_DEVICE, 3'h0, 7'h06);
    raw(4'h0, 5'h00, 10);
    rd(STFM_RD_DEVICE, 3'h0, 7'h06);
    rd(STFM_RD_DEVICE, 3'h0, 7'h00);
    wr(5'h1F);
    raw(4'h4, 5'h00, 800);
    outs(5'h00);
    raw(4'h0, 5'h00, 10);
    wr(5'h1F);
    raw(4'h8, 5'h00, 900);
    outs(5'h00);
    rd(STFM_RD_QUICK, 3'h0, 7'h60);
    wr(5'h1F);
    inr_base = inr_count;
    raw(4'h0, 5'h00, 20);
    outs(5'h1F);
    chk(7'(inr_count - inr_base), 7'h01);
    rd(STFM_RD_QUICK, 3'h0, 7'h60);
    rd(STFM_RD_QUICK, 3'h0, 7'h00);
    @(posedge clk_sys_i);
    fail_mode_i <= 1'b1;
    raw(4'h1, 5'h00, 800);
    outs(5'h00);
    raw(4'h0, 5'h00, 30);
    outs(5'h00);
    cyc(90);
    outs(5'h1F);
    raw(4'h0, 5'h01, 1100);
    raw(4'h0, 5'h00, 150);
    outs(5'h1E);
    wr(5'h1F);
    outs(5'h1E);
    @(posedge clk_sys_i);
    mode_i <= 1'b1;
    @(posedge clk_sys_i);
    mode_i <= 1'b0;
    cyc(10);
    outs(5'h1F);
    @(posedge clk_sys_i);
    warn_sel_i <= 1'b1;
    cyc(6);
    chk({6'h00, warn_low_o}, 7'h01);
    @(posedge clk_sys_i);
    warn_sel_i <= 1'b0;
    cyc(6);
    chk({6'h00, warn_low_o}, 7'h00);
    // second power-up with the pump still unsettled
    @(posedge clk_sys_i);
    resetn_i <= 1'b0;
    flt      <= 4'h8;
    repeat (3) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    wr(5'h1F);
    outs(5'h00);
    inr_base = inr_count;
    raw(4'h0, 5'h00, 12);
    outs(5'h1F);
    chk(7'(inr_count - inr_base), 7'h01);
    results();
  end
endmodule
